// File: core/pll_clk_pkg.sv
// constants for the pll mode control and base clock selector
package pll_clk_pkg;
   // register addresses
   localparam logic [7:0] CTRL_ADDR  = 8'h3A;
   localparam logic [7:0] BW_ADDR    = 8'h3B;
   localparam logic [7:0] MULH_ADDR  = 8'h3C;
   localparam logic [7:0] MULL_ADDR  = 8'h3D;
   localparam logic [7:0] RDIV_ADDR  = 8'h3F;
   localparam logic [7:0] RANGE_ADDR = 8'h40;
   // pll_control_reg fields
   localparam int CTRL_IE_BIT   = 7;
   localparam int CTRL_FLAG_BIT = 6;
   localparam int CTRL_PON_BIT  = 5;
   localparam int CTRL_BCS_BIT  = 4;
   localparam int CTRL_PRE_MSB  = 3;
   localparam int CTRL_PRE_LSB  = 2;
   // bandwidth register fields
   localparam int BW_AUTO_BIT = 7;
   localparam int BW_LOCK_BIT = 6;
   localparam int BW_TRK_BIT  = 5;
   // field widths
   localparam int MULH_W = 4;
   localparam int RDIV_W = 4;
   // reset values
   localparam logic        PON_RST   = 1'b1;
   localparam logic [1:0]  PRE_RST   = 2'h2;
   localparam logic [11:0] MUL_RST   = 12'h002;
   localparam logic [3:0]  RDIV_RST  = 4'h1;
   localparam logic [7:0]  RANGE_RST = 8'h01;
   // source clock cycles waited on a base clock change
   localparam logic [1:0]  SWITCH_EDGES = 2'h3;
   typedef enum logic [1:0] {
      SEL_RUN  = 2'b00,
      SEL_WAIT = 2'b01,
      SEL_SWAP = 2'b10
   } sel_state_t;
endpackage

// File: core/pll_mode_clock_select.sv
// pll filter mode, lock tracking, programming values and base clock selector
//
// Overview of operation
// - acquisition mode shows the filter tracking flag as zero.
// - filter tracks whenever not acquiring or the tracking flag is one.
// - in automatic bandwidth the lock detector switches filter modes itself.
// - in automatic mode the tracking flag is read-only and shows filter mode.
// - tracking flag sets inside track window, clears outside untrack window.
// - lock indicator sets inside lock window, clears outside unlock window.
// - a lock toggle with interrupt enable set raises an interrupt request.
// - vco over two to the prescale equals four times bus frequency.
// - vco equals reference times two-power prescale times multiplier over divider.
// - zero divider or multiplier acts exactly as one.
// - zero vco range disables the pll and blocks pll base clock selection.
// - on source change base clock output holds while three cycles of crystal and, with pll enabled, pll clock pass.
// - selector output is divided by two for an even duty cycle.
// - base clock select bit picks crystal or pll as base clock.
// - vco selection is refused while pll power is off.
// - pll stays powered while the vco is the base clock source.
// - the same selector picks crystal or vco for the usb clock.
// - select one uses pll halves and vco; zero uses crystal halves and crystal.
// - without automatic mode irq enable, change flag and lock read zero.
// - change flag sets on each lock toggle, clears on control register read.
//
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module pll_mode_clock_select
   import pll_clk_pkg::*;
(
   // clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        reset_n_i,
   // register port
   input  wire logic [7:0]  addr_i,
   input  wire logic [7:0]  wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [7:0]  rdata_o,
   // frequency window comparators from the analog loop
   input  wire logic        in_track_tol_i,
   input  wire logic        out_untrack_tol_i,
   input  wire logic        in_lock_tol_i,
   input  wire logic        out_unlock_tol_i,
   // source clocks, oversampled as levels
   input  wire logic        crystal_clock_i,
   input  wire logic        pll_clock_i,
   input  wire logic        vco_clock_i,
   // generated clocks and interrupt
   output logic             base_clock_out_o,
   output logic             usb_ref_clock_o,
   output logic             irq_o,
   // controls to the analog loop
   output logic             pll_enable_o,
   output logic             filter_tracking_o,
   output logic      [1:0]  prescale_o,
   output logic      [11:0] multiplier_o,
   output logic      [3:0]  ref_divider_o,
   output logic      [7:0]  vco_range_o
);
   localparam int NSYNC = 7;

   // two-flop synchronisers; only the second stage feeds logic
   logic [NSYNC-1:0] async_in;
   logic [NSYNC-1:0] meta_q;
   logic [NSYNC-1:0] sync_q;
   logic [1:0]       clk_prev_q;
   assign async_in = {vco_clock_i, pll_clock_i, crystal_clock_i,
                      out_unlock_tol_i, in_lock_tol_i, out_untrack_tol_i, in_track_tol_i};
   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++) begin : g_sync
         always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
               meta_q[gi] <= 1'b0;
               sync_q[gi] <= 1'b0;
            end else begin
               meta_q[gi] <= async_in[gi];
               sync_q[gi] <= meta_q[gi];
            end
         end
      end
   endgenerate

   wire in_trk_s  = sync_q[0];
   wire out_unt_s = sync_q[1];
   wire in_lock_s = sync_q[2];
   wire out_unl_s = sync_q[3];
   wire xclk_s    = sync_q[4];
   wire pclk_s    = sync_q[5];
   wire vclk_s    = sync_q[6];
   wire xclk_rise = xclk_s & ~clk_prev_q[0];
   wire pclk_rise = pclk_s & ~clk_prev_q[1];

   // register state
   logic        ie_q, flag_q, pon_q, bcs_q, auto_q, lock_q, trk_q;
   logic [1:0]  pre_q;
   logic [11:0] mul_q;
   logic [3:0]  rdiv_q;
   logic [7:0]  range_q;
   logic [7:0]  rdata_q;
   logic        irq_q, pll_en_q;
   logic [11:0] mul_eff_q;
   logic [3:0]  rdiv_eff_q;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
      hit = (a == reg_addr);
   endfunction

   wire wr_ctrl  = wr_i & hit(addr_i, CTRL_ADDR);
   wire wr_bw    = wr_i & hit(addr_i, BW_ADDR);
   // programming values lock while pll power is on
   wire prog_ok  = ~pon_q;
   wire wr_mulh  = wr_i & hit(addr_i, MULH_ADDR) & prog_ok;
   wire wr_mull  = wr_i & hit(addr_i, MULL_ADDR) & prog_ok;
   wire wr_rdiv  = wr_i & hit(addr_i, RDIV_ADDR) & prog_ok;
   wire wr_range = wr_i & hit(addr_i, RANGE_ADDR) & prog_ok;
   wire rd_ctrl  = rd_i & hit(addr_i, CTRL_ADDR);
   wire range_ok = (range_q != 8'h00);

   // control register next values
   wire auto_d = wr_bw ? wdata_i[BW_AUTO_BIT] : auto_q;
   wire ie_d   = auto_d & (wr_ctrl ? wdata_i[CTRL_IE_BIT] : ie_q);
   // select being set in this very write also keeps power on
   wire pon_d;
   // setting the select looks at the power bit already held, not this write
   wire bcs_d  = pon_q & range_ok & (wr_ctrl ? wdata_i[CTRL_BCS_BIT] : bcs_q);
   wire [1:0] pre_d = wr_ctrl ? wdata_i[CTRL_PRE_MSB:CTRL_PRE_LSB] : pre_q;
   assign pon_d = bcs_q | bcs_d | (wr_ctrl ? wdata_i[CTRL_PON_BIT] : pon_q);

   // lock detector with hysteresis, cleared outside automatic mode
   wire lock_d = auto_d & (lock_q ? ~out_unl_s : in_lock_s);
   // filter mode: hardware in automatic mode, software otherwise
   wire trk_auto = trk_q ? ~out_unt_s : in_trk_s;
   wire trk_d  = auto_q ? trk_auto : (wr_bw ? wdata_i[BW_TRK_BIT] : trk_q);
   // a toggle in the read cycle still sets the flag
   wire flag_d = auto_d & ((lock_d != lock_q) | (flag_q & ~rd_ctrl));

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ie_q   <= 1'b0;
         flag_q <= 1'b0;
         pon_q  <= PON_RST;
         bcs_q  <= 1'b0;
         pre_q  <= PRE_RST;
         auto_q <= 1'b0;
         lock_q <= 1'b0;
         trk_q  <= 1'b0;
      end else begin
         ie_q   <= ie_d;
         flag_q <= flag_d;
         pon_q  <= pon_d;
         bcs_q  <= bcs_d;
         pre_q  <= pre_d;
         auto_q <= auto_d;
         lock_q <= lock_d;
         trk_q  <= trk_d;
      end
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         mul_q   <= MUL_RST;
         rdiv_q  <= RDIV_RST;
         range_q <= RANGE_RST;
      end else begin
         if (wr_mulh)
            mul_q[11:8] <= wdata_i[MULH_W-1:0];
         if (wr_mull)
            mul_q[7:0] <= wdata_i;
         if (wr_rdiv)
            rdiv_q <= wdata_i[RDIV_W-1:0];
         if (wr_range)
            range_q <= wdata_i;
      end
   end

   // read mux; unmapped addresses read zero
   wire [7:0] ctrl_rd = {ie_q, flag_q, pon_q, bcs_q, pre_q, 2'b00};
   wire [7:0] bw_rd   = {auto_q, lock_q, trk_q, 5'h00};
   wire [7:0] rd_mux  = hit(addr_i, CTRL_ADDR)  ? ctrl_rd :
                        hit(addr_i, BW_ADDR)    ? bw_rd :
                        hit(addr_i, MULH_ADDR)  ? {4'h0, mul_q[11:8]} :
                        hit(addr_i, MULL_ADDR)  ? mul_q[7:0] :
                        hit(addr_i, RDIV_ADDR)  ? {4'h0, rdiv_q} :
                        hit(addr_i, RANGE_ADDR) ? range_q : 8'h00;

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i)
         rdata_q <= 8'h00;
      else
         rdata_q <= rd_i ? rd_mux : 8'h00;
   end

   // analog loop controls; zero multiplier or divider means one
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         irq_q      <= 1'b0;
         pll_en_q   <= 1'b0;
         mul_eff_q  <= MUL_RST;
         rdiv_eff_q <= RDIV_RST;
      end else begin
         irq_q      <= flag_d & ie_d;
         pll_en_q   <= pon_d & range_ok;
         mul_eff_q  <= (mul_q == 12'h000) ? 12'h001 : mul_q;
         rdiv_eff_q <= (rdiv_q == 4'h0) ? 4'h1 : rdiv_q;
      end
   end

   // base clock selector
   sel_state_t  state_q, state_d;
   logic        sel_q, base_q, usb_q;
   logic [1:0]  xcnt_q, pcnt_q;
   // a stopped pll clock cannot be waited for, so it counts as done
   wire x_done  = (xcnt_q == SWITCH_EDGES);
   wire p_done  = (pcnt_q == SWITCH_EDGES) | ~pll_en_q;
   wire src_now = sel_q ? pclk_s : xclk_s;
   wire src_rise = sel_q ? pclk_rise : xclk_rise;

   always_comb begin
      state_d = state_q;
      case (state_q)
         SEL_RUN:  if (bcs_q != sel_q) state_d = SEL_WAIT;
         SEL_WAIT: if (x_done & p_done) state_d = SEL_SWAP;
         SEL_SWAP: if (~xclk_s & ~pclk_s) state_d = SEL_RUN;
         default:  state_d = SEL_RUN;
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_q    <= SEL_RUN;
         sel_q      <= 1'b0;
         xcnt_q     <= 2'h0;
         pcnt_q     <= 2'h0;
         clk_prev_q <= 2'h0;
      end else begin
         state_q    <= state_d;
         clk_prev_q <= {pclk_s, xclk_s};
         if (state_q == SEL_RUN) begin
            xcnt_q <= 2'h0;
            pcnt_q <= 2'h0;
         end else begin
            if (xclk_rise && !x_done)
               xcnt_q <= xcnt_q + 2'h1;
            if (pclk_rise && pcnt_q != SWITCH_EDGES)
               pcnt_q <= pcnt_q + 2'h1;
         end
         if (state_q == SEL_SWAP && state_d == SEL_RUN)
            sel_q <= bcs_q;
      end
   end

   // base clock output held in stasis outside the run state
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         base_q <= 1'b0;
         usb_q  <= 1'b0;
      end else begin
         if (state_q == SEL_RUN && src_rise)
            base_q <= ~base_q;
         usb_q <= sel_q ? vclk_s : xclk_s;
      end
   end

   assign rdata_o           = rdata_q;
   assign base_clock_out_o  = base_q;
   assign usb_ref_clock_o   = usb_q;
   assign irq_o             = irq_q;
   assign pll_enable_o      = pll_en_q;
   assign filter_tracking_o = trk_q;
   assign prescale_o        = pre_q;
   assign multiplier_o      = mul_eff_q;
   assign ref_divider_o     = rdiv_eff_q;
   assign vco_range_o       = range_q;

   // checks
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);

   property p_trk_set;
      auto_q && !trk_q && in_trk_s |=> trk_q;
   endproperty
   a_trk_set: assert property (p_trk_set) else $error("tracking not entered");

   property p_trk_clear;
      auto_q && trk_q && out_unt_s |=> !filter_tracking_o;
   endproperty
   a_trk_clear: assert property (p_trk_clear) else $error("tracking not left");

   property p_trk_ro;
      auto_q && wr_bw && !in_trk_s && !out_unt_s |=> $stable(trk_q);
   endproperty
   a_trk_ro: assert property (p_trk_ro) else $error("tracking flag written");

   property p_lock_set;
      auto_q && wdata_i[BW_AUTO_BIT] && wr_bw && in_lock_s |=> lock_q;
   endproperty
   a_lock_set: assert property (p_lock_set) else $error("lock not set");

   property p_irq;
      $changed(lock_q) && $past(ie_q) && ie_q |-> irq_o;
   endproperty
   a_irq: assert property (p_irq) else $error("missing lock irq");

   property p_nonzero;
      multiplier_o != 12'h000 && ref_divider_o != 4'h0;
   endproperty
   a_nonzero: assert property (p_nonzero) else $error("zero divider out");

   property p_range;
      range_q == 8'h00 |-> !bcs_q && !pll_enable_o;
   endproperty
   a_range: assert property (p_range) else $error("pll used with zero range");

   property p_stasis;
      state_q != SEL_RUN |=> $stable(base_clock_out_o);
   endproperty
   a_stasis: assert property (p_stasis) else $error("base clock moved in swap");

   property p_pon;
      bcs_q |-> pon_q;
   endproperty
   a_pon: assert property (p_pon) else $error("select without power");

   property p_manual;
      !auto_q |-> !ie_q && !flag_q && !lock_q;
   endproperty
   a_manual: assert property (p_manual) else $error("auto-only bits set");

   property p_flag_clr;
      rd_ctrl && !$changed(lock_d) && lock_d == lock_q |=> !flag_q;
   endproperty
   a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared");

   c_switch_pll: cover property (state_q == SEL_SWAP && bcs_q ##1 sel_q);
   c_lock_irq:   cover property ($rose(lock_q) ##1 irq_o);
   c_flag_read:  cover property (flag_q && rd_ctrl ##1 !flag_q);
endmodule
`default_nettype wire

// File: test/bus_clock_consumer_model.sv
// source clocks for the selector and period monitor of the derived clocks
`timescale 1ns/1ps
`default_nettype none
module bus_clock_consumer_model #(
   parameter real XTAL_HALF_NS = 200.0,
   parameter real PLL_HALF_NS  = 125.0,
   parameter real VCO_HALF_NS  = 75.0
) (
   // source clocks
   output logic        crystal_clock_o,
   output logic        pll_clock_o,
   output logic        vco_clock_o,
   // derived clocks watched
   input  wire logic   base_clock_i,
   input  wire logic   usb_clock_i,
   // last measured periods in ns
   output logic [15:0] base_period_o,
   output logic [15:0] usb_period_o
);
   realtime base_t;
   realtime usb_t;
   // odd start offsets keep the sources unrelated to the system clock
   initial begin
      crystal_clock_o = 1'b0;
      #7;
      forever #(XTAL_HALF_NS) crystal_clock_o = ~crystal_clock_o;
   end
   initial begin
      pll_clock_o = 1'b0;
      #11;
      forever #(PLL_HALF_NS) pll_clock_o = ~pll_clock_o;
   end
   initial begin
      vco_clock_o = 1'b0;
      #3;
      forever #(VCO_HALF_NS) vco_clock_o = ~vco_clock_o;
   end
   initial begin
      base_t = 0.0;
      usb_t = 0.0;
      base_period_o = 16'h0000;
      usb_period_o = 16'h0000;
   end
   // bus clock derivation only needs the base period
   always @(posedge base_clock_i) begin
      base_period_o = 16'($rtoi($realtime - base_t));
      base_t = $realtime;
   end
   always @(posedge usb_clock_i) begin
      usb_period_o = 16'($rtoi($realtime - usb_t));
      usb_t = $realtime;
   end
endmodule
`default_nettype wire

// File: test/tb_pll_mode_clock_select.sv
// register, lock and base clock selector tests
`timescale 1ns/1ps
`default_nettype none
module tb_pll_mode_clock_select;
   import pll_clk_pkg::*;
   logic sys_clk, reset_n, wr, rd, base, usb, irq, pll_en, trk, stasis_err, base_hold;
   logic in_trk, out_untrk, in_lock, out_unlock, xclk, pclk, vclk;
   logic [7:0] addr, wdata, rdata, range;
   logic [1:0] pre;
   logic [11:0] mul;
   logic [3:0] rdiv;
   logic [15:0] base_per, usb_per;
   int mismatches, samples_checked;

   pll_mode_clock_select dut (.sys_clk_i(sys_clk), .reset_n_i(reset_n), .addr_i(addr),
      .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .in_track_tol_i(in_trk),
      .out_untrack_tol_i(out_untrk), .in_lock_tol_i(in_lock), .out_unlock_tol_i(out_unlock),
      .crystal_clock_i(xclk), .pll_clock_i(pclk), .vco_clock_i(vclk),
      .base_clock_out_o(base), .usb_ref_clock_o(usb), .irq_o(irq), .pll_enable_o(pll_en),
      .filter_tracking_o(trk), .prescale_o(pre), .multiplier_o(mul), .ref_divider_o(rdiv),
      .vco_range_o(range));
   bus_clock_consumer_model sim (.crystal_clock_o(xclk), .pll_clock_o(pclk),
      .vco_clock_o(vclk), .base_clock_i(base), .usb_clock_i(usb),
      .base_period_o(base_per), .usb_period_o(usb_per));

   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one source sample of jitter on each measured edge
   task automatic chk_near(input string what, input int exp, input logic [15:0] got);
      samples_checked++;
      if ((got >= 16'(exp - 30) && got <= 16'(exp + 30)) !== 1'b1) begin
         mismatches++;
         $display("mismatch %s expected %0d seen %0d", what, exp, got);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge sys_clk);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge sys_clk);
      rd <= 1'b0;
      #1;
      chk($sformatf("reg %h", a), {8'h00, exp}, {8'h00, rdata});
   endtask

   initial begin
      #200000;
      mismatches++;
      $display("watchdog expired");
      give_verdict;
   end

   initial begin
      {reset_n, wr, rd, in_trk, out_untrk, in_lock, out_unlock} = '0;
      addr = 8'h00;
      wdata = 8'h00;
      repeat (5) @(posedge sys_clk);
      reset_n <= 1'b1;
      // reset values, unmapped hole reads zero
      rd_reg(CTRL_ADDR, 8'h28);
      rd_reg(BW_ADDR, 8'h00);
      rd_reg(MULH_ADDR, 8'h00);
      rd_reg(MULL_ADDR, 8'h02);
      rd_reg(RDIV_ADDR, 8'h01);
      rd_reg(RANGE_ADDR, 8'h01);
      rd_reg(8'h3E, 8'h00);
      chk("pll_enable", 16'h1, {15'h0, pll_en});
      for (int p = 0; p < 4; p++) begin
         wr_reg(CTRL_ADDR, 8'h20 | 8'(p << 2));
         cyc(2);
         chk("prescale", 16'(p), {14'h0, pre});
      end
      $display("test reset and prescale done");
      wr_reg(CTRL_ADDR, 8'h08);
      wr_reg(RDIV_ADDR, 8'h00);
      wr_reg(MULH_ADDR, 8'h00);
      wr_reg(MULL_ADDR, 8'h00);
      cyc(2);
      chk("divider", 16'h1, {12'h0, rdiv});
      chk("multiplier", 16'h1, {4'h0, mul});
      wr_reg(MULH_ADDR, 8'h0A);
      wr_reg(MULL_ADDR, 8'h5C);
      wr_reg(RDIV_ADDR, 8'h03);
      cyc(2);
      chk("multiplier", 16'h0A5C, {4'h0, mul});
      chk("divider", 16'h3, {12'h0, rdiv});
      wr_reg(CTRL_ADDR, 8'h18);
      rd_reg(CTRL_ADDR, 8'h08);
      wr_reg(RANGE_ADDR, 8'h00);
      wr_reg(CTRL_ADDR, 8'h28);
      cyc(2);
      chk("pll_enable", 16'h0, {15'h0, pll_en});
      chk("vco range", 16'h0, {8'h00, range});
      wr_reg(CTRL_ADDR, 8'h38);
      rd_reg(CTRL_ADDR, 8'h28);
      wr_reg(CTRL_ADDR, 8'h08);
      wr_reg(RANGE_ADDR, 8'h01);
      wr_reg(CTRL_ADDR, 8'h28);
      cyc(2);
      chk("pll_enable", 16'h1, {15'h0, pll_en});
      chk("vco range", 16'h1, {8'h00, range});
      $display("test programming done");
      wr_reg(BW_ADDR, 8'h20);
      cyc(2);
      chk("tracking", 16'h1, {15'h0, trk});
      wr_reg(BW_ADDR, 8'h00);
      cyc(2);
      chk("tracking", 16'h0, {15'h0, trk});
      in_lock <= 1'b1;
      wr_reg(CTRL_ADDR, 8'hA8);
      cyc(6);
      rd_reg(CTRL_ADDR, 8'h28);
      rd_reg(BW_ADDR, 8'h00);
      chk("irq", 16'h0, {15'h0, irq});
      $display("test manual mode done");
      wr_reg(BW_ADDR, 8'h80);
      wr_reg(CTRL_ADDR, 8'hA8);
      cyc(6);
      chk("irq", 16'h1, {15'h0, irq});
      rd_reg(BW_ADDR, 8'hC0);
      rd_reg(CTRL_ADDR, 8'hE8);
      rd_reg(CTRL_ADDR, 8'hA8);
      chk("irq", 16'h0, {15'h0, irq});
      wr_reg(BW_ADDR, 8'hA0);
      rd_reg(BW_ADDR, 8'hC0);
      in_trk <= 1'b1;
      cyc(6);
      chk("tracking", 16'h1, {15'h0, trk});
      rd_reg(BW_ADDR, 8'hE0);
      in_trk <= 1'b0;
      cyc(6);
      chk("tracking", 16'h1, {15'h0, trk});
      out_untrk <= 1'b1;
      cyc(6);
      chk("tracking", 16'h0, {15'h0, trk});
      in_lock <= 1'b0;
      cyc(6);
      rd_reg(BW_ADDR, 8'hC0);
      out_unlock <= 1'b1;
      cyc(6);
      chk("irq", 16'h1, {15'h0, irq});
      rd_reg(BW_ADDR, 8'h80);
      rd_reg(CTRL_ADDR, 8'hE8);
      out_unlock <= 1'b0;
      in_lock <= 1'b1;
      cyc(6);
      rd_reg(CTRL_ADDR, 8'hE8);
      $display("test automatic mode done");
      cyc(100);
      chk_near("base period", 800, base_per);
      chk_near("usb period", 400, usb_per);
      wr_reg(CTRL_ADDR, 8'h38);
      cyc(3);
      stasis_err = 1'b0;
      base_hold = base;
      repeat (30) begin
         cyc(1);
         if (base !== base_hold)
            stasis_err = 1'b1;
      end
      chk("stasis", 16'h0, {15'h0, stasis_err});
      cyc(300);
      chk_near("base period", 500, base_per);
      chk_near("usb period", 150, usb_per);
      wr_reg(CTRL_ADDR, 8'h18);
      rd_reg(CTRL_ADDR, 8'h38);
      // lock lost while the pll clock drives the base clock: fall back to crystal
      in_lock <= 1'b0;
      out_unlock <= 1'b1;
      cyc(6);
      rd_reg(BW_ADDR, 8'h80);
      wr_reg(CTRL_ADDR, 8'h28);
      cyc(300);
      chk_near("base period", 800, base_per);
      chk_near("usb period", 400, usb_per);
      $display("test base clock select done");
      give_verdict;
   end
endmodule
`default_nettype wire
